// ---- rtl/deser_output_config_regs.sv ----
// Output configuration register bank of the serial video deserializer.
// Assumes a same-clock register master with one-cycle strobes and an
// asynchronous strap level that is stable for a few cycles after reset.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module deser_output_config_regs
  import deser_cfg_pkg::*;
#(
  parameter int LOOP_W = 1                  // Width of recovered loop data
) (
  input  wire logic [ADDR_W-1:0]     CLOCK_UNUSED_GUARD_ADDR,
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire logic [DATA_W-1:0]     WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [DATA_W-1:0]     RDATA,
  input  wire logic [STRAP_W-1:0]    MODE_STRAP_PIN,
  input  wire logic [LOOP_W-1:0]     RECEIVE_PORT_ZERO_DATA,
  input  wire logic [LOOP_W-1:0]     RECEIVE_PORT_ONE_DATA,
  output logic [FLOOR_W-1:0]         EQ_FLOOR_START_P0,
  output logic [FLOOR_W-1:0]         EQ_FLOOR_START_P1,
  output logic [FLOOR_EN_W-1:0]      EQ_FLOOR_ENABLE,
  output logic                       BIT_MAP_MODE,
  output logic [CODE_W-1:0]          DISPLAY_OUTPUT_ARRANGEMENT,
  output logic [CODE_W-1:0]          OUTPUT_SWING_CODE,
  output logic                       LOOP_SOURCE_PORT,
  output logic [LOOP_ALT_W-1:0]      LOOP_SOURCE_PORT_ALT,
  output logic                       LOOP_DRIVER_ENABLE,
  output logic [LOOP_W-1:0]          LOOP_THROUGH_OUTPUT
);
  // The address port carries a plain name for the register bus
  logic [ADDR_W-1:0] addr;
  assign addr = CLOCK_UNUSED_GUARD_ADDR;

  // Address decode, one hit per mapped offset
  logic hit_floor_en;                       // Floor enable register
  logic hit_floor;                          // Equalizer floor register
  logic hit_mode;                           // Output arrangement register
  logic hit_port;                           // Second-port select register
  logic hit_swing;                          // Swing control register
  logic hit_lsel;                           // Loop source select register
  logic hit_len;                            // Loop driver enable register
  logic hit_lalt;                           // Second loop select register

  assign hit_floor_en = (addr == OFS_FLOOR_EN);
  assign hit_floor    = (addr == OFS_EQ_FLOOR);
  assign hit_mode     = (addr == OFS_OUT_MODE);
  assign hit_port     = (addr == OFS_PORT_SEL);
  assign hit_swing    = (addr == OFS_SWING);
  assign hit_lsel     = (addr == OFS_LOOP_SEL);
  assign hit_len      = (addr == OFS_LOOP_EN);
  assign hit_lalt     = (addr == OFS_LOOP_ALT);

  // Stored control state
  logic                  port_sel_ff;       // Steers floor access to port one
  logic [FLOOR_EN_W-1:0] floor_en_ff;       // Floor feature enable
  logic                  map_ovr_ff;        // Bit-mapping override enable
  logic                  map_reg_ff;        // Bit-mapping register value
  logic                  map_strap_ff;      // Strapped bit-mapping mode
  logic [CODE_W-1:0]     arr_ff;            // Display output arrangement
  logic [CODE_W-1:0]     swing_ff;          // Output swing code
  logic                  lsel_ff;           // Loop source port
  logic                  len_ff;            // Loop driver enable
  logic [LOOP_ALT_W-1:0] lalt_ff;           // Second loop port select
  logic [DATA_W-1:0]     rdata_ff;          // Registered read data
  logic [LOOP_W-1:0]     loop_ff;           // Loop-through data
  logic                  map_out_ff;        // Effective bit-mapping mode

  // Per-port floor fields share one module
  field_reg_if #(.WIDTH(FLOOR_W)) floor0_if ();
  field_reg_if #(.WIDTH(FLOOR_W)) floor1_if ();

  // A floor write lands only in the port picked by the select bit
  assign floor0_if.we = WR && hit_floor && !port_sel_ff;   // [RULE2]
  assign floor1_if.we = WR && hit_floor && port_sel_ff;    // [RULE2]
  assign floor0_if.wd = WDATA[FLOOR_LSB +: FLOOR_W];
  assign floor1_if.wd = WDATA[FLOOR_LSB +: FLOOR_W];

  // Port zero floor, resets to eight
  field_reg #(.WIDTH(FLOOR_W), .RESET(FLOOR_RST)) u_floor0 (
    .CLOCK (CLOCK),
    .RST   (RST),
    .fld   (floor0_if.owner)
  );

  // Port one floor, resets to eight
  field_reg #(.WIDTH(FLOOR_W), .RESET(FLOOR_RST)) u_floor1 (
    .CLOCK (CLOCK),
    .RST   (RST),
    .fld   (floor1_if.owner)
  );

  // Strap synchroniser: the first stage feeds only the second
  logic [STRAP_W-1:0] strap_s1_ff;
  logic [STRAP_W-1:0] strap_s2_ff;
  logic [STRAP_W-1:0] strap_s3_ff;
  logic               strap_stable;         // Second and third stages agree

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      strap_s1_ff <= '0;
      strap_s2_ff <= '0;
      strap_s3_ff <= '0;
    end else begin
      strap_s1_ff <= MODE_STRAP_PIN;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
    end
  end

  assign strap_stable = (strap_s2_ff == strap_s3_ff);

  // Strap capture happens once after reset release, since a reset
  // flop may only take constants; the pin is then ignored until the next reset
  strap_state_e strap_st_ff;
  strap_state_e nxt_strap_st;
  logic         strap_take;                 // Latch strap this cycle
  logic [1:0]   strap_fill_ff;              // Cycles until chain is filled

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      strap_fill_ff <= 2'h0;
    end else if (strap_fill_ff != STRAP_FILL_DONE) begin
      strap_fill_ff <= strap_fill_ff + 2'h1;
    end
  end

  always_comb begin
    nxt_strap_st = strap_st_ff;
    strap_take   = 1'b0;
    case (strap_st_ff)
      ST_STRAP_WAIT: begin
        // Wait until the chain holds real samples that agree
        if ((strap_fill_ff == STRAP_FILL_DONE) && strap_stable) begin
          strap_take   = 1'b1;
          nxt_strap_st = ST_STRAP_DONE;
        end
      end
      ST_STRAP_DONE: begin
        nxt_strap_st = ST_STRAP_DONE;
      end
      default: begin
        nxt_strap_st = ST_STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      strap_st_ff <= ST_STRAP_WAIT;
    end else begin
      strap_st_ff <= nxt_strap_st;
    end
  end

  // Strapped bit-mapping mode, read-only to software
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      map_strap_ff <= 1'b0;
    end else if (strap_take) begin
      map_strap_ff <= strap_s3_ff[STRAP_MAP_BIT];       // [RULE3]
    end
  end

  // Arrangement field: strap load, then software owns it; a write
  // in the capture cycle wins; a write before the capture is overwritten
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      arr_ff <= ARR_DUAL;
    end else if (WR && hit_mode) begin
      arr_ff <= WDATA[OUT_MODE_LSB +: CODE_W];          // [RULE6]
    end else if (strap_take) begin
      arr_ff <= strap_s3_ff[OUT_MODE_LSB +: CODE_W];    // [RULE6]
    end
  end

  // Override enable and register value for bit-mapping mode
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      map_ovr_ff <= 1'b0;                               // [RULE4]
      map_reg_ff <= 1'b0;                               // [RULE4]
    end else if (WR && hit_mode) begin
      map_ovr_ff <= WDATA[MAP_OVR_BIT];
      map_reg_ff <= WDATA[MAP_REG_BIT];
    end
  end

  // Second-port select, a bank of its own
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      port_sel_ff <= 1'b0;
    end else if (WR && hit_port) begin
      port_sel_ff <= WDATA[PORT_SEL_BIT];
    end
  end

  // Floor feature enable
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      floor_en_ff <= FLOOR_EN_RST;
    end else if (WR && hit_floor_en) begin
      floor_en_ff <= WDATA[FLOOR_EN_LSB +: FLOOR_EN_W];
    end
  end

  // Output swing code, reset to setting zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      swing_ff <= CODE_RST;                             // [RULE7]
    end else if (WR && hit_swing) begin
      swing_ff <= WDATA[SWING_LSB +: CODE_W];           // [RULE7]
    end
  end

  // Loop-through controls; only documented bits are stored
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lsel_ff <= 1'b0;
      len_ff  <= 1'b0;                                  // [RULE11]
      lalt_ff <= LOOP_ALT_RST;
    end else begin
      if (WR && hit_lsel) begin
        lsel_ff <= WDATA[LOOP_SEL_BIT];                 // [RULE8]
      end
      if (WR && hit_len) begin
        len_ff <= WDATA[LOOP_EN_BIT];                   // [RULE11]
      end
      if (WR && hit_lalt) begin
        // Kept in step with the source bit by software [RULE10]
        lalt_ff <= WDATA[LOOP_ALT_LSB +: LOOP_ALT_W];
      end
    end
  end

  // Read mux: one cycle latency, zero for reserved bits and holes
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = READ_ZERO;                              // [RULE12]
    if (hit_floor) begin
      nxt_rdata[FLOOR_LSB +: FLOOR_W] =
        port_sel_ff ? floor1_if.q : floor0_if.q;        // [RULE2]
    end else if (hit_floor_en) begin
      nxt_rdata[FLOOR_EN_LSB +: FLOOR_EN_W] = floor_en_ff;
    end else if (hit_mode) begin
      nxt_rdata[MAP_STAT_BIT] = map_strap_ff;           // [RULE3]
      nxt_rdata[MAP_OVR_BIT]  = map_ovr_ff;
      nxt_rdata[MAP_REG_BIT]  = map_reg_ff;
      nxt_rdata[OUT_MODE_LSB +: CODE_W] = arr_ff;
    end else if (hit_port) begin
      nxt_rdata[PORT_SEL_BIT] = port_sel_ff;
    end else if (hit_swing) begin
      nxt_rdata[SWING_LSB +: CODE_W] = swing_ff;
    end else if (hit_lsel) begin
      nxt_rdata[LOOP_SEL_BIT] = lsel_ff;
    end else if (hit_len) begin
      nxt_rdata[LOOP_EN_BIT] = len_ff;
    end else if (hit_lalt) begin
      nxt_rdata[LOOP_ALT_LSB +: LOOP_ALT_W] = lalt_ff;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_ff <= READ_ZERO;
    end else if (RD) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= READ_ZERO;
    end
  end

  // Effective bit-mapping mode
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      map_out_ff <= 1'b0;
    end else begin
      map_out_ff <= map_ovr_ff ? map_reg_ff : map_strap_ff;  // [RULE4]
    end
  end

  // Loop-through data path; silent while the driver is off, which is
  // why software must enable it first [RULE9]
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      loop_ff <= '0;
    end else if (!len_ff) begin
      loop_ff <= '0;                                    // [RULE11]
    end else if (lsel_ff) begin
      loop_ff <= RECEIVE_PORT_ONE_DATA;                 // [RULE8]
    end else begin
      loop_ff <= RECEIVE_PORT_ZERO_DATA;                // [RULE8]
    end
  end

  // Floor start points go to the equalizer, which starts there when
  // the enable field is nonzero [RULE1]
  assign EQ_FLOOR_START_P0 = floor0_if.q;
  assign EQ_FLOOR_START_P1 = floor1_if.q;
  assign EQ_FLOOR_ENABLE   = floor_en_ff;               // [RULE1]

  // Arrangement codes pass straight to the transmit ports [RULE5]
  assign DISPLAY_OUTPUT_ARRANGEMENT = arr_ff;
  assign OUTPUT_SWING_CODE          = swing_ff;
  assign BIT_MAP_MODE               = map_out_ff;
  assign LOOP_SOURCE_PORT           = lsel_ff;
  assign LOOP_SOURCE_PORT_ALT       = lalt_ff;
  assign LOOP_DRIVER_ENABLE         = len_ff;
  assign LOOP_THROUGH_OUTPUT        = loop_ff;
  assign RDATA                      = rdata_ff;
endmodule
`default_nettype wire

// ---- rtl/deser_cfg_pkg.sv ----
// Constants for the output configuration register bank.
// Assumes an 8-bit register port on the device's single core clock.
// Notes on behaviour
// (RULE1) Four-bit equalizer floor, reset eight, start point
// (RULE2) Second-port select steers floor register to port one
// (RULE3) Mode bit seven reports strapped bit-mapping mode
// (RULE4) Override bit six selects register bit five
// (RULE5) Arrangement codes: dual, swapped, single, replicated
// (RULE6) Arrangement field loaded from strap at reset; code resets it to dual and loads the strap after release
// (RULE7) Two-bit swing code, reset zero, four settings
// (RULE8) Loop source bit seven picks receive port
// (RULE9) Software enables loop driver before expecting data
// (RULE10) Software keeps both loop port selects consistent
// (RULE11) Loop driver enable bit three, reset off
// (RULE12) Reserved bits read zero, writes ignored
package deser_cfg_pkg;
  localparam int ADDR_W = 8;                // Register address width
  localparam int DATA_W = 8;                // Register data width
  localparam int FLOOR_W = 4;               // Equalizer floor width
  localparam int CODE_W = 2;                // Arrangement and swing code width

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_FLOOR_EN = 8'h35;
  localparam logic [ADDR_W-1:0] OFS_EQ_FLOOR = 8'h45;
  localparam logic [ADDR_W-1:0] OFS_OUT_MODE = 8'h49;
  localparam logic [ADDR_W-1:0] OFS_PORT_SEL = 8'h4F;
  localparam logic [ADDR_W-1:0] OFS_SWING    = 8'h4B;
  localparam logic [ADDR_W-1:0] OFS_LOOP_SEL = 8'h52;
  localparam logic [ADDR_W-1:0] OFS_LOOP_EN  = 8'h56;
  localparam logic [ADDR_W-1:0] OFS_LOOP_ALT = 8'h57;

  // Field positions
  localparam int FLOOR_LSB    = 0;
  localparam int FLOOR_EN_LSB = 4;
  localparam int FLOOR_EN_W   = 2;
  localparam int MAP_STAT_BIT = 7;
  localparam int MAP_OVR_BIT  = 6;
  localparam int MAP_REG_BIT  = 5;
  localparam int OUT_MODE_LSB = 0;
  localparam int SWING_LSB    = 0;
  localparam int PORT_SEL_BIT = 0;
  localparam int LOOP_SEL_BIT = 7;
  localparam int LOOP_EN_BIT  = 3;
  localparam int LOOP_ALT_LSB = 1;
  localparam int LOOP_ALT_W   = 2;
  localparam int STRAP_W      = 3;          // Strap: {map mode, arrangement}
  localparam int STRAP_MAP_BIT = 2;

  // Reset values
  localparam logic [FLOOR_W-1:0]    FLOOR_RST    = 4'h8;
  localparam logic [FLOOR_EN_W-1:0] FLOOR_EN_RST = 2'h0;
  localparam logic [CODE_W-1:0]     CODE_RST     = 2'h0;
  localparam logic [LOOP_ALT_W-1:0] LOOP_ALT_RST = 2'h0;
  localparam logic [DATA_W-1:0]     READ_ZERO    = 8'h00;
  localparam logic [1:0]            STRAP_FILL_DONE = 2'h3;  // Edges to fill the strap chain

  // Display output arrangement codes
  localparam logic [CODE_W-1:0] ARR_DUAL      = 2'h0;
  localparam logic [CODE_W-1:0] ARR_DUAL_SWAP = 2'h1;
  localparam logic [CODE_W-1:0] ARR_SINGLE    = 2'h2;
  localparam logic [CODE_W-1:0] ARR_REPLICATE = 2'h3;

  // Strap capture sequencing
  typedef enum logic {ST_STRAP_WAIT, ST_STRAP_DONE} strap_state_e;
endpackage

// ---- rtl/field_reg_if.sv ----
// Interface between the register bank and one stored field.
// Assumes the owner and the user share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface field_reg_if #(parameter int WIDTH = 4);
  logic             we;   // One-cycle write enable
  logic [WIDTH-1:0] wd;   // Write data
  logic [WIDTH-1:0] q;    // Stored value
  modport owner (input we, input wd, output q);
  modport user  (output we, output wd, input q);
endinterface
`default_nettype wire

// ---- rtl/field_reg.sv ----
// One read/write field with a constant reset value.
// Assumes write enable and data come from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module field_reg #(
  parameter int               WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic   CLOCK,
  input  wire logic   RST,
  field_reg_if.owner  fld
);
  logic [WIDTH-1:0] value_ff;   // Held field value

  // Store on write; reset takes the constant only
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      value_ff <= RESET;
    end else if (fld.we) begin
      value_ff <= fld.wd;
    end
  end

  assign fld.q = value_ff;
endmodule
`default_nettype wire

// ---- tb/deser_output_config_regs_assertions.sv ----
// Checker for the output configuration register bank.
// Assumes binding onto the bank's top module; one core clock domain.
`timescale 1ns/1ps
`default_nettype none
module deser_output_config_regs_checker
  import deser_cfg_pkg::*;
#(
  parameter int LOOP_W = 1                       // Width of recovered loop data
) (
  input wire logic [ADDR_W-1:0]  CLOCK_UNUSED_GUARD_ADDR,
  input wire logic               CLOCK,
  input wire logic               RST,
  input wire logic [DATA_W-1:0]  WDATA,
  input wire logic               WR,
  input wire logic               RD,
  input wire logic [DATA_W-1:0]  RDATA,
  input wire logic [LOOP_W-1:0]  RECEIVE_PORT_ZERO_DATA,
  input wire logic [LOOP_W-1:0]  RECEIVE_PORT_ONE_DATA,
  input wire logic [FLOOR_W-1:0] EQ_FLOOR_START_P0,
  input wire logic [FLOOR_W-1:0] EQ_FLOOR_START_P1,
  input wire logic               BIT_MAP_MODE,
  input wire logic [CODE_W-1:0]  DISPLAY_OUTPUT_ARRANGEMENT,
  input wire logic [CODE_W-1:0]  OUTPUT_SWING_CODE,
  input wire logic               LOOP_SOURCE_PORT,
  input wire logic               LOOP_DRIVER_ENABLE,
  input wire logic [LOOP_W-1:0]  LOOP_THROUGH_OUTPUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic psel_ff;  // Own copy of the second-port select
  logic ovr_ff;   // Own copy of the map override bit
  logic mreg_ff;  // Own copy of the register map bit
  logic wfl;      // Write to the floor register
  logic wmd;      // Write to the mode register
  assign wfl = WR && (CLOCK_UNUSED_GUARD_ADDR == OFS_EQ_FLOOR);
  assign wmd = WR && (CLOCK_UNUSED_GUARD_ADDR == OFS_OUT_MODE);
  // Shadows of hidden controls, so that steering can be judged from ports
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      psel_ff <= 1'b0;
      ovr_ff  <= 1'b0;
      mreg_ff <= 1'b0;
    end else if (WR && CLOCK_UNUSED_GUARD_ADDR == OFS_PORT_SEL) begin
      psel_ff <= WDATA[PORT_SEL_BIT];
    end else if (wmd) begin
      ovr_ff  <= WDATA[MAP_OVR_BIT];
      mreg_ff <= WDATA[MAP_REG_BIT];
    end
  end
  property p_floor_wr;
    wfl |=> (psel_ff ? EQ_FLOOR_START_P1 : EQ_FLOOR_START_P0) == $past(WDATA[3:0]);
  endproperty
  property p_floor_hold;
    !wfl |=> $stable(EQ_FLOOR_START_P0) && $stable(EQ_FLOOR_START_P1);
  endproperty
  // Waits for one quiet edge, since the mode output lags the register
  property p_map_ovr;
    ovr_ff && $stable(ovr_ff) && $stable(mreg_ff) |-> BIT_MAP_MODE == mreg_ff;
  endproperty
  property p_arr_wr;
    wmd |=> DISPLAY_OUTPUT_ARRANGEMENT == $past(WDATA[1:0]);
  endproperty
  property p_swing_wr;
    WR && CLOCK_UNUSED_GUARD_ADDR == OFS_SWING |=> OUTPUT_SWING_CODE == $past(WDATA[1:0]);
  endproperty
  property p_src_wr;
    WR && CLOCK_UNUSED_GUARD_ADDR == OFS_LOOP_SEL |=> LOOP_SOURCE_PORT == $past(WDATA[7]);
  endproperty
  property p_en_wr;
    WR && CLOCK_UNUSED_GUARD_ADDR == OFS_LOOP_EN |=> LOOP_DRIVER_ENABLE == $past(WDATA[3]);
  endproperty
  property p_loop_on;
    LOOP_DRIVER_ENABLE |=> LOOP_THROUGH_OUTPUT == $past(LOOP_SOURCE_PORT ?
      RECEIVE_PORT_ONE_DATA : RECEIVE_PORT_ZERO_DATA);
  endproperty
  property p_loop_off;
    !LOOP_DRIVER_ENABLE |=> LOOP_THROUGH_OUTPUT == '0;
  endproperty
  property p_rd_idle;
    !RD |=> RDATA == READ_ZERO;
  endproperty
  property p_rd_mode;
    RD && CLOCK_UNUSED_GUARD_ADDR == OFS_OUT_MODE |=>
      RDATA[4:2] == 3'h0 && RDATA[1:0] == $past(DISPLAY_OUTPUT_ARRANGEMENT);
  endproperty
  a_floor_wr:   assert property (p_floor_wr) else $error("floor write misrouted");
  a_floor_hold: assert property (p_floor_hold) else $error("floor moved unasked");
  a_map_ovr:    assert property (p_map_ovr) else $error("override map bit ignored");
  a_arr_wr:     assert property (p_arr_wr) else $error("arrangement not written");
  a_swing_wr:   assert property (p_swing_wr) else $error("swing not written");
  a_src_wr:     assert property (p_src_wr) else $error("loop source not written");
  a_en_wr:      assert property (p_en_wr) else $error("loop enable not written");
  a_loop_on:    assert property (p_loop_on) else $error("loop data wrong port");
  a_loop_off:   assert property (p_loop_off) else $error("loop data while off");
  a_rd_idle:    assert property (p_rd_idle) else $error("read data outside slot");
  a_rd_mode:    assert property (p_rd_mode) else $error("mode readback wrong");
  c_floor_p1: cover property (wfl && psel_ff);
  c_ovr_low:  cover property (ovr_ff && !mreg_ff);
  c_loop_p1:  cover property (LOOP_DRIVER_ENABLE && LOOP_SOURCE_PORT);
endmodule
bind deser_output_config_regs deser_output_config_regs_checker #(.LOOP_W(LOOP_W)) chk_u (
  .CLOCK_UNUSED_GUARD_ADDR, .CLOCK, .RST, .WDATA, .WR, .RD, .RDATA,
  .RECEIVE_PORT_ZERO_DATA, .RECEIVE_PORT_ONE_DATA, .EQ_FLOOR_START_P0,
  .EQ_FLOOR_START_P1, .BIT_MAP_MODE, .DISPLAY_OUTPUT_ARRANGEMENT,
  .OUTPUT_SWING_CODE, .LOOP_SOURCE_PORT, .LOOP_DRIVER_ENABLE, .LOOP_THROUGH_OUTPUT
);
`default_nettype wire

// ---- tb/deser_output_config_regs_tb_top.sv ----
// Self-checking bench for the output configuration register bank.
// Assumes the bank, its package and its bound checker compile beside it.
`timescale 1ns/1ps
`default_nettype none
module deser_output_config_regs_tb_top
  import deser_cfg_pkg::*;
;
  logic                  clock;     // Core clock, 4 ns period
  logic                  rst;       // Asynchronous reset
  logic [ADDR_W-1:0]     addr;      // Register address
  logic [DATA_W-1:0]     wdata;     // Write data
  logic                  wr;        // Write strobe
  logic                  rd;        // Read strobe
  logic [DATA_W-1:0]     rdata;     // Read data
  logic [STRAP_W-1:0]    strap;     // Strap: map mode one, single output
  logic                  p0_d;      // Port zero recovered data
  logic                  p1_d;      // Port one recovered data
  logic [FLOOR_W-1:0]    fl0;       // Floor of port zero
  logic [FLOOR_W-1:0]    fl1;       // Floor of port one
  logic [FLOOR_EN_W-1:0] fl_en;     // Floor enable field
  logic                  map_mode;  // Effective bit-mapping mode
  logic [CODE_W-1:0]     arr;       // Output arrangement
  logic [CODE_W-1:0]     swing;     // Swing code
  logic                  src;       // Loop source port
  logic [LOOP_ALT_W-1:0] alt;       // Second loop select
  logic                  en;        // Loop driver enable
  logic                  loop_out;  // Loop-through data
  int                    bad_count; // Mismatches
  int                    tests_run; // Comparisons made
  int                    cycles;    // Hang guard
  deser_output_config_regs #(.LOOP_W(1)) dut_u (
    .CLOCK_UNUSED_GUARD_ADDR(addr), .CLOCK(clock), .RST(rst), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .MODE_STRAP_PIN(strap),
    .RECEIVE_PORT_ZERO_DATA(p0_d), .RECEIVE_PORT_ONE_DATA(p1_d),
    .EQ_FLOOR_START_P0(fl0), .EQ_FLOOR_START_P1(fl1), .EQ_FLOOR_ENABLE(fl_en),
    .BIT_MAP_MODE(map_mode), .DISPLAY_OUTPUT_ARRANGEMENT(arr),
    .OUTPUT_SWING_CODE(swing), .LOOP_SOURCE_PORT(src), .LOOP_SOURCE_PORT_ALT(alt),
    .LOOP_DRIVER_ENABLE(en), .LOOP_THROUGH_OUTPUT(loop_out)
  );
  // Free-running core clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write; an idle cycle follows so the strobe is never driven twice
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic t_reset;
    reg_rd(OFS_EQ_FLOOR, 8'h08, "floor reset");
    chk("floor1 reset", 8'h08, {4'h0, fl1});
    reg_rd(OFS_SWING, 8'h00, "swing reset");
    reg_rd(OFS_LOOP_SEL, 8'h00, "source reset");
    reg_rd(OFS_LOOP_EN, 8'h00, "enable reset");
    reg_rd(OFS_OUT_MODE, 8'h82, "mode strap");
    chk("map strap", 8'h01, {7'h00, map_mode});
  endtask
  task automatic t_floor;
    reg_wr(OFS_EQ_FLOOR, 8'hF5);
    chk("floor0", 8'h05, {4'h0, fl0});
    reg_rd(OFS_EQ_FLOOR, 8'h05, "floor0 rd");
    reg_wr(OFS_PORT_SEL, 8'h01);
    reg_wr(OFS_EQ_FLOOR, 8'h03);
    chk("floor1", 8'h03, {4'h0, fl1});
    chk("floor0 kept", 8'h05, {4'h0, fl0});
    reg_rd(OFS_EQ_FLOOR, 8'h03, "floor1 rd");
    reg_wr(OFS_PORT_SEL, 8'h00);
    reg_rd(OFS_EQ_FLOOR, 8'h05, "floor0 back");
    reg_wr(OFS_FLOOR_EN, 8'hFF);
    chk("floor en", 8'h03, {6'h00, fl_en});
    reg_rd(OFS_FLOOR_EN, 8'h30, "floor en rd");
  endtask
  task automatic t_mode;
    logic [7:0] wv [3] = '{8'h40, 8'h00, 8'h60};
    logic       mv [3] = '{1'b0, 1'b1, 1'b1};
    for (int c = 0; c < 4; c++) begin
      reg_wr(OFS_OUT_MODE, 8'h1C | 8'(c));
      chk("arrangement", 8'(c), {6'h00, arr});
      reg_rd(OFS_OUT_MODE, 8'h80 | 8'(c), "mode rd");
    end
    // Override off after on shows the strap level again
    for (int i = 0; i < 3; i++) begin
      reg_wr(OFS_OUT_MODE, wv[i]);
      @(posedge clock);
      #1;
      chk("map mode", {7'h00, mv[i]}, {7'h00, map_mode});
    end
  endtask
  task automatic t_swing;
    for (int c = 0; c < 4; c++) begin
      reg_wr(OFS_SWING, 8'hFC | 8'(c));
      chk("swing", 8'(c), {6'h00, swing});
      reg_rd(OFS_SWING, 8'(c), "swing rd");
    end
  endtask
  task automatic t_loop;
    chk("loop off", 8'h00, {7'h00, loop_out});
    reg_wr(OFS_LOOP_ALT, 8'h02);
    reg_wr(OFS_LOOP_EN, 8'hFF);
    reg_rd(OFS_LOOP_EN, 8'h08, "enable rd");
    chk("enable out", 8'h01, {7'h00, en});
    chk("loop port0", 8'h01, {7'h00, loop_out});
    reg_wr(OFS_LOOP_ALT, 8'h04);
    reg_wr(OFS_LOOP_SEL, 8'hFF);
    reg_rd(OFS_LOOP_SEL, 8'h80, "source rd");
    reg_rd(OFS_LOOP_ALT, 8'h04, "alt rd");
    chk("alt out", 8'h02, {6'h00, alt});
    chk("source out", 8'h01, {7'h00, src});
    chk("loop port1", 8'h00, {7'h00, loop_out});
    @(posedge clock);
    p1_d <= 1'b1;
    @(posedge clock);
    #1;
    chk("loop port1 hi", 8'h01, {7'h00, loop_out});
    reg_wr(OFS_LOOP_EN, 8'h00);
    @(posedge clock);
    #1;
    chk("loop disabled", 8'h00, {7'h00, loop_out});
  endtask
  task automatic t_unmapped;
    reg_wr(8'h60, 8'hFF);
    reg_rd(8'h60, 8'h00, "unmapped rd");
    chk("swing kept", 8'h03, {6'h00, swing});
  endtask
  // Mid-run reset with another strap: map mode zero, swapped dual
  task automatic t_restrap;
    @(posedge clock);
    rst   <= 1'b1;
    strap <= 3'h1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    reg_rd(OFS_OUT_MODE, 8'h01, "mode restrap");
    chk("map restrap", 8'h00, {7'h00, map_mode});
    chk("arr restrap", 8'h01, {6'h00, arr});
    chk("swing re-reset", 8'h00, {6'h00, swing});
    chk("enable re-reset", 8'h00, {7'h00, en});
    chk("source re-reset", 8'h00, {7'h00, src});
    chk("floor0 re-reset", 8'h08, {4'h0, fl0});
  endtask
  // Main sequence
  initial begin
    {rst, addr, wdata, wr, rd, p0_d, p1_d} = '0;
    {bad_count, tests_run, cycles} = '0;
    rst   = 1'b1;
    strap = 3'h6;
    p0_d  = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Leaves room for the strap capture before any check
    repeat (8) @(posedge clock);
    t_reset();
    t_floor();
    t_mode();
    t_swing();
    t_loop();
    t_unmapped();
    t_restrap();
    wrap_up();
  end
endmodule
`default_nettype wire
